// ===== rtl/pci_pm_capability.sv
// Summary of operation
// - Header bits 7:0 always read 01h, the power-management capability tag.
// - Header bits 15:8 always read 00h, ending the capability list.
// - After powerup reset capability defaults FFC2h with aux supply, else 7E02h.
// - EEPROM may override; without aux, cold wake and aux current forced zero.
// - Capability bits 14:11 read 1; bit 15 follows loaded cold-wake default.
// - Capability bits 10 and 9 read 1, states D2 and D1 supported.
// - Capability bits 8:6 report aux current need from the loaded default.
// - Capability bits 5, 4 and 3 read 0; no clock needed for wake.
// - Capability bits 2:0 read constant 010b.
// - Control/status word is untouched by the internal D3hot-to-D0 reset.
// - With cold wake, flag and gate survive PCI reset; else all cleared.
// - Wake flag sets on every wake event regardless of the gate.
// - Writing 1 clears the flag and releases wake output unless a wake event coincides; 0 does nothing.
// - Gate bit 8 clear means wake output is never driven.
// - Select bits 12:9 choose reported power data; only 0..7 valid.
// - Scale bits 14:13 follow the currently selected power-data index.
// - Control bits 7:5, 4 and 3:2 always read 0.
// - Power level bits 1:0 written by software and read back as current.
`timescale 1ns/1ps
`default_nettype none
`include "pci_pm_map.svh"

module pci_pm_capability
  import pci_pm_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   pciReset_n,
  input  wire logic                   auxPresentPin,
  input  wire logic                   eepromCapLoad,
  input  wire logic [15:0]            eepromCapWord,
  input  wire logic                   eepromScaleLoad,
  input  wire logic [2:0]             eepromScaleIndex,
  input  wire logic [1:0]             eepromScaleValue,
  input  wire logic                   wakeEvent,
  input  wire logic                   cfgRead,
  input  wire logic                   cfgWrite,
  input  wire logic [5:0]             cfgDword,
  input  wire logic [3:0]             cfgByteEn,
  input  wire logic [31:0]            cfgWriteData,
  output logic [31:0]                 cfgReadData,
  output logic                        cfgAck,
  output logic                        cfgHit,
  output pci_pm_pkg::power_level_type devicePowerLevel,
  output logic                        hotResetPulse,
  output logic                        capReady,
  output logic                        wakeOut,
  output logic                        wakeOutEnable
);
  import pci_pm_pkg::*;

  // ****************************************************************
  // address and access decode
  // ****************************************************************
  function automatic logic isDword(input logic [5:0] dword, input logic [5:0] target);
    isDword = (dword == target);
  endfunction

  logic hitHeader;
  logic hitControl;
  logic anyAccess;
  logic ctrlWrite;
  logic levelWrite;
  logic upperWrite;

  assign hitHeader  = isDword(cfgDword, `PM_HEADER_DWORD);
  assign hitControl = isDword(cfgDword, `PM_CONTROL_DWORD);
  assign anyAccess  = cfgRead | cfgWrite;
  assign ctrlWrite  = cfgWrite & hitControl;
  assign levelWrite = ctrlWrite & cfgByteEn[0];
  assign upperWrite = ctrlWrite & cfgByteEn[1];

  // ****************************************************************
  // capability word source
  // ****************************************************************
  logic [15:0] capWord;
  logic        auxPresent;
  logic        coldWake;

  pm_cap_loader uLoader (
    .clk           (clk),
    .rst_n         (rst_n),
    .auxPresentPin (auxPresentPin),
    .eepromCapLoad (eepromCapLoad),
    .eepromCapWord (eepromCapWord),
    .capReady      (capReady),
    .auxPresent    (auxPresent),
    .capWord       (capWord)
  );

  assign coldWake = capWord[`PM_CAP_COLD_BIT];

  // ****************************************************************
  // control/status storage
  // ****************************************************************
  logic            flag_q;
  logic            flag_d;
  logic            gate_q;
  logic            gate_d;
  logic [3:0]      select_q;
  logic [3:0]      select_d;
  power_level_type level_q;
  power_level_type level_d;
  logic            flagClear;
  logic            stickyKeep;
  logic            pciClear;

  // a write of 1 clears; a wake event in the same cycle still sets
  assign flagClear = upperWrite & cfgWriteData[`PM_CSR_FLAG_BIT];
  assign flag_d    = wakeEvent | (flag_q & ~flagClear);

  assign gate_d   = upperWrite ? cfgWriteData[`PM_CSR_GATE_BIT] : gate_q;
  assign select_d = upperWrite ? cfgWriteData[`PM_CSR_SELECT_HI:`PM_CSR_SELECT_LO] : select_q;
  assign level_d  = levelWrite ?
                    power_level_type'(cfgWriteData[`PM_CSR_LEVEL_HI:`PM_CSR_LEVEL_LO]) :
                    level_q;

  assign pciClear   = ~pciReset_n;
  assign stickyKeep = coldWake;

  // powerup reset clears everything; pci reset spares flag and gate only with cold wake
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      gate_q <= 1'b0;
    end else if (pciClear && !stickyKeep) begin
      flag_q <= 1'b0;
      gate_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      gate_q <= gate_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || pciClear) begin
      select_q <= 4'h0;
      level_q  <= LEVEL_D0;
    end else begin
      select_q <= select_d;
      level_q  <= level_d;
    end
  end

  // ****************************************************************
  // internal reset on leaving D3hot
  // ****************************************************************
  // drives the rest of the function; this register stays out of it
  logic hotExit;
  logic hotReset_q;

  assign hotExit = levelWrite && (level_q == LEVEL_D3) &&
                   (power_level_type'(cfgWriteData[`PM_CSR_LEVEL_HI:`PM_CSR_LEVEL_LO])
                    == LEVEL_D0);

  always_ff @(posedge clk) begin
    if (!rst_n || pciClear) begin
      hotReset_q <= 1'b0;
    end else begin
      hotReset_q <= hotExit;
    end
  end

  assign hotResetPulse    = hotReset_q;
  assign devicePowerLevel = level_q;

  // ****************************************************************
  // power-data scale selection
  // ****************************************************************
  logic [1:0] scale;

  pm_scale_table uScale (
    .clk            (clk),
    .rst_n          (rst_n),
    .scaleLoad      (eepromScaleLoad),
    .scaleLoadIndex (eepromScaleIndex),
    .scaleLoadValue (eepromScaleValue),
    .selectIndex    (select_q),
    .scaleOut       (scale)
  );

  // ****************************************************************
  // read-back words
  // ****************************************************************
  logic [15:0] headerWord;
  logic [15:0] controlWord;
  logic [31:0] readMux;

  assign headerWord[7:0]  = `PM_CAP_TAG_VALUE;
  assign headerWord[15:8] = `PM_NEXT_ITEM_VALUE;

  assign controlWord[`PM_CSR_FLAG_BIT] = flag_q;
  assign controlWord[`PM_CSR_SCALE_HI:`PM_CSR_SCALE_LO] = scale;
  assign controlWord[`PM_CSR_SELECT_HI:`PM_CSR_SELECT_LO] = select_q;
  assign controlWord[`PM_CSR_GATE_BIT] = gate_q;
  assign controlWord[7:2] = 6'h00;
  assign controlWord[`PM_CSR_LEVEL_HI:`PM_CSR_LEVEL_LO] = level_q;

  // bridge extension and power-data bytes above read as zero here
  assign readMux = hitHeader  ? {capWord, headerWord} :
                   hitControl ? {16'h0000, controlWord} :
                                32'h0000_0000;

  // ****************************************************************
  // configuration answer
  // ****************************************************************
  logic [31:0] readData_q;
  logic        ack_q;
  logic        hit_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      readData_q <= 32'h0000_0000;
      ack_q      <= 1'b0;
      hit_q      <= 1'b0;
    end else begin
      readData_q <= cfgRead ? readMux : 32'h0000_0000;
      ack_q      <= anyAccess;
      hit_q      <= anyAccess & (hitHeader | hitControl);
    end
  end

  assign cfgReadData = readData_q;
  assign cfgAck      = ack_q;
  assign cfgHit      = hit_q;

  // ****************************************************************
  // wake output, open drain
  // ****************************************************************
  logic wakeDrive_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wakeDrive_q <= 1'b0;
    end else begin
      wakeDrive_q <= flag_d & gate_d & ~(pciClear & ~stickyKeep);
    end
  end

  // the pin only ever pulls low; release lets the system pull-up win
  assign wakeOut       = 1'b0;
  assign wakeOutEnable = wakeDrive_q;

endmodule

`default_nettype wire

// ===== rtl/pci_pm_map.svh
`ifndef PCI_PM_MAP_SVH
`define PCI_PM_MAP_SVH

// ****************************************************************
// configuration offsets (byte addresses and dword indices)
// ****************************************************************
`define PM_CAP_HEADER_OFS     8'h44
`define POWER_CAPABILITIES_OFS   8'h46
`define PM_CONTROL_STATUS_OFS 8'h48
`define PM_HEADER_DWORD       6'h11
`define PM_CONTROL_DWORD      6'h12

// ****************************************************************
// capability header fields
// ****************************************************************
`define PM_CAP_TAG_VALUE      8'h01
`define PM_NEXT_ITEM_VALUE    8'h00
`define PM_CAP_HEADER_RESET   16'h0001

// ****************************************************************
// capability word fields and defaults
// ****************************************************************
`define PM_CAP_DEFAULT_AUX    16'hffc2
`define PM_CAP_DEFAULT_NOAUX  16'h7e02
`define PM_CAP_COLD_BIT       15
`define PM_CAP_WAKE_HI        14
`define PM_CAP_WAKE_LO        11
`define PM_CAP_STATE_TWO_BIT  10
`define PM_CAP_STATE_ONE_BIT  9
`define PM_CAP_AUX_HI         8
`define PM_CAP_AUX_LO         6
`define PM_CAP_DSI_BIT        5
`define PM_CAP_RSVD_BIT       4
`define PM_CAP_CLOCK_BIT      3
`define PM_CAP_REV_HI         2
`define PM_CAP_REV_LO         0
`define PM_SPEC_REVISION      3'h2

// ****************************************************************
// control/status fields
// ****************************************************************
`define PM_CSR_RESET          16'h0000
`define PM_CSR_FLAG_BIT       15
`define PM_CSR_SCALE_HI       14
`define PM_CSR_SCALE_LO       13
`define PM_CSR_SELECT_HI      12
`define PM_CSR_SELECT_LO      9
`define PM_CSR_GATE_BIT       8
`define PM_CSR_LEVEL_HI       1
`define PM_CSR_LEVEL_LO       0
`define PM_SELECT_VALID_TOP   4'h7

// ****************************************************************
// timing counts
// ****************************************************************
`define PM_SYNC_STAGES        2
`define PM_SETTLE_CYCLES      2'h2

`endif

// ===== rtl/pci_pm_pkg.sv
package pci_pm_pkg;

  typedef enum logic [1:0] {
    LEVEL_D0 = 2'h0,
    LEVEL_D1 = 2'h1,
    LEVEL_D2 = 2'h2,
    LEVEL_D3 = 2'h3
  } power_level_type;

  typedef enum logic [2:0] {
    CAP_SETTLE = 3'h1,
    CAP_LATCH  = 3'h2,
    CAP_READY  = 3'h4
  } cap_load_state_type;

endpackage

// ===== rtl/pm_cap_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_pm_map.svh"

module pm_cap_loader
  import pci_pm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        auxPresentPin,
  input  wire logic        eepromCapLoad,
  input  wire logic [15:0] eepromCapWord,
  output logic             capReady,
  output logic             auxPresent,
  output logic [15:0]      capWord
);
  import pci_pm_pkg::*;

  // ****************************************************************
  // aux pin synchroniser, first stage read by second only
  // ****************************************************************
  logic auxMeta_q;
  logic auxSync_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      auxMeta_q <= 1'b0;
      auxSync_q <= 1'b0;
    end else begin
      auxMeta_q <= auxPresentPin;
      auxSync_q <= auxMeta_q;
    end
  end

  // ****************************************************************
  // strap capture after powerup reset release
  // ****************************************************************
  cap_load_state_type state_q;
  cap_load_state_type state_d;
  logic [1:0]         settle_q;
  logic               coldWake_q;
  logic [2:0]         auxNeed_q;
  logic [15:0]        strapDefault;

  // strap is only trusted once the synchroniser has refilled
  always_comb begin
    case (state_q)
      CAP_SETTLE: state_d = (settle_q == `PM_SETTLE_CYCLES) ? CAP_LATCH : CAP_SETTLE;
      CAP_LATCH:  state_d = CAP_READY;
      CAP_READY:  state_d = CAP_READY;
      default:    state_d = CAP_SETTLE;
    endcase
  end

  assign strapDefault = auxSync_q ? `PM_CAP_DEFAULT_AUX : `PM_CAP_DEFAULT_NOAUX;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= CAP_SETTLE;
      settle_q   <= 2'h0;
      coldWake_q <= 1'b0;
      auxNeed_q  <= 3'h0;
    end else begin
      state_q <= state_d;
      if (state_q == CAP_SETTLE) begin
        settle_q <= settle_q + 2'h1;
      end
      if (state_q == CAP_LATCH) begin
        coldWake_q <= strapDefault[`PM_CAP_COLD_BIT];
        auxNeed_q  <= strapDefault[`PM_CAP_AUX_HI:`PM_CAP_AUX_LO];
      end else if (state_q == CAP_READY && eepromCapLoad) begin
        coldWake_q <= eepromCapWord[`PM_CAP_COLD_BIT];
        auxNeed_q  <= eepromCapWord[`PM_CAP_AUX_HI:`PM_CAP_AUX_LO];
      end
    end
  end

  // ****************************************************************
  // assembled capability word
  // ****************************************************************
  // fixed fields are not taken from the eeprom image
  assign capWord[`PM_CAP_COLD_BIT] = coldWake_q & auxSync_q;
  assign capWord[`PM_CAP_WAKE_HI:`PM_CAP_WAKE_LO] = 4'hf;
  assign capWord[`PM_CAP_STATE_TWO_BIT] = 1'b1;
  assign capWord[`PM_CAP_STATE_ONE_BIT] = 1'b1;
  assign capWord[`PM_CAP_AUX_HI:`PM_CAP_AUX_LO] = auxSync_q ? auxNeed_q : 3'h0;
  assign capWord[`PM_CAP_DSI_BIT] = 1'b0;
  assign capWord[`PM_CAP_RSVD_BIT] = 1'b0;
  assign capWord[`PM_CAP_CLOCK_BIT] = 1'b0;
  assign capWord[`PM_CAP_REV_HI:`PM_CAP_REV_LO] = `PM_SPEC_REVISION;

  assign capReady   = (state_q == CAP_READY);
  assign auxPresent = auxSync_q;

endmodule

`default_nettype wire

// ===== rtl/pm_scale_table.sv
`timescale 1ns/1ps
`default_nettype none
`include "pci_pm_map.svh"

module pm_scale_table (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scaleLoad,
  input  wire logic [2:0] scaleLoadIndex,
  input  wire logic [1:0] scaleLoadValue,
  input  wire logic [3:0] selectIndex,
  output logic [1:0]      scaleOut
);

  // ****************************************************************
  // eight scale entries, one per valid select value
  // ****************************************************************
  logic [1:0] scale_q [0:7];

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gEntry
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          scale_q[i] <= 2'h0;
        end else if (scaleLoad && scaleLoadIndex == 3'(i)) begin
          scale_q[i] <= scaleLoadValue;
        end
      end
    end
  endgenerate

  logic selectValid;

  // indices 8..15 are reserved and report no scale
  assign selectValid = (selectIndex <= `PM_SELECT_VALID_TOP);
  assign scaleOut    = selectValid ? scale_q[selectIndex[2:0]] : 2'h0;

endmodule

`default_nettype wire

// ===== bench/cfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
  input  wire logic        clk,
  input  wire logic        cfgAck,
  input  wire logic [31:0] cfgReadData,
  output logic             cfgRead,
  output logic             cfgWrite,
  output logic [5:0]       cfgDword,
  output logic [3:0]       cfgByteEn,
  output logic [31:0]      cfgWriteData
);
  initial begin
    cfgRead = 1'b0;
    cfgWrite = 1'b0;
    cfgDword = 6'h3f;
    cfgByteEn = 4'h0;
    cfgWriteData = 32'h0;
  end

  // ****************************************************************
  // config access: one-cycle strobe, answer awaited a bounded time
  // ****************************************************************
  // idle lines are inverted so stale address or data never looks valid
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
    int n;
    @(negedge clk);
    cfgRead <= !wr;
    cfgWrite <= wr;
    cfgDword <= dw;
    cfgByteEn <= be;
    cfgWriteData <= wd;
    ok = 1'b0;
    rd = 32'h0;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk);
      cfgRead <= 1'b0;
      cfgWrite <= 1'b0;
      cfgDword <= ~dw;
      cfgWriteData <= ~wd;
      ok = (cfgAck === 1'b1);
      rd = cfgReadData;
    end
  endtask
endmodule

`default_nettype wire

// ===== bench/pci_pm_capability_chk.sv
`timescale 1ns/1ps
`default_nettype none

module pci_pm_capability_chk
  import pci_pm_pkg::*;
(
  input wire logic                        clk,
  input wire logic                        rst_n,
  input wire logic                        pciReset_n,
  input wire logic                        wakeEvent,
  input wire logic                        cfgRead,
  input wire logic                        cfgWrite,
  input wire logic [5:0]                  cfgDword,
  input wire logic [3:0]                  cfgByteEn,
  input wire logic [31:0]                 cfgWriteData,
  input wire logic [31:0]                 cfgReadData,
  input wire logic                        cfgAck,
  input wire logic                        cfgHit,
  input wire pci_pm_pkg::power_level_type devicePowerLevel,
  input wire logic                        hotResetPulse,
  input wire logic                        capReady,
  input wire logic                        wakeOut,
  input wire logic                        wakeOutEnable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire logic mapped = (cfgDword == 6'h11) || (cfgDword == 6'h12);
  wire logic csrWr  = cfgWrite && (cfgDword == 6'h12) && pciReset_n;

  // ****************************************************************
  // properties
  // ****************************************************************
  AST_ACK_HIT: assert property ((cfgRead || cfgWrite) |=> cfgAck && (cfgHit == $past(mapped)))
    else $error("access not answered");
  AST_IDLE: assert property (!(cfgRead || cfgWrite) |=> !cfgAck && !cfgHit)
    else $error("answer without access");
  AST_HEADER: assert property (cfgRead && cfgDword == 6'h11 |=> cfgReadData[15:0] == 16'h0001)
    else $error("header word wrong");
  AST_CAP_FIXED: assert property (cfgRead && cfgDword == 6'h11 && capReady
    |=> cfgReadData[30:25] == 6'h3f && cfgReadData[21:16] == 6'h02)
    else $error("capability fixed bits wrong");
  AST_CSR_ZERO: assert property (cfgRead && cfgDword == 6'h12
    |=> cfgReadData[7:2] == 6'h0 && cfgReadData[31:16] == 16'h0)
    else $error("control reserved bits nonzero");
  AST_EMPTY_DATA: assert property (cfgWrite || (cfgRead && !mapped) |=> cfgReadData == 32'h0)
    else $error("data returned on write or unmapped read");
  AST_LEVEL: assert property (csrWr && cfgByteEn[0] |=> devicePowerLevel == $past(cfgWriteData[1:0]))
    else $error("power level not taken");
  AST_HOT: assert property (csrWr && cfgByteEn[0] && cfgWriteData[1:0] == 2'h0
    && devicePowerLevel == LEVEL_D3 |=> hotResetPulse ##1 !hotResetPulse)
    else $error("hot reset pulse wrong");
  AST_GATE_OFF: assert property (csrWr && cfgByteEn[1] && !cfgWriteData[8] |=> !wakeOutEnable)
    else $error("wake driven with gate clear");
  AST_CLEAR: assert property (csrWr && cfgByteEn[1] && cfgWriteData[15] && !wakeEvent
    |=> !wakeOutEnable)
    else $error("wake output not released");
  AST_PIN_LOW: assert property (wakeOutEnable |-> !wakeOut)
    else $error("wake pin not pulled low");
  AST_READY: assert property ($rose(rst_n) |-> ##[1:6] capReady)
    else $error("capability not ready");

  cover property (hotResetPulse);
  cover property ($rose(wakeOutEnable));
  cover property (cfgRead && cfgDword == 6'h11 && capReady);
endmodule

`default_nettype wire

// ===== bench/pci_pm_capability_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pci_pm_capability_tb;
  import pci_pm_pkg::*;

  logic            clk = 1'b0;
  logic            rst_n = 1'b0;
  logic            pciReset_n = 1'b1;
  logic            auxPresentPin = 1'b1;
  logic            eepromCapLoad = 1'b0;
  logic [15:0]     eepromCapWord = 16'h0;
  logic            eepromScaleLoad = 1'b0;
  logic [2:0]      eepromScaleIndex = 3'h0;
  logic [1:0]      eepromScaleValue = 2'h0;
  logic            wakeEvent = 1'b0;
  logic            hotSeen;
  wire logic       cfgRead, cfgWrite, cfgAck, cfgHit, hotResetPulse, capReady;
  wire logic       wakeOut, wakeOutEnable;
  wire logic [5:0] cfgDword;
  wire logic [3:0] cfgByteEn;
  wire logic [31:0] cfgWriteData, cfgReadData;
  power_level_type devicePowerLevel;
  int              n_errors = 0;
  int              tests_run = 0;
  int              i;

  always #5 clk = ~clk;

  cfg_host_model u_cfg_host_model (.clk(clk), .cfgAck(cfgAck), .cfgReadData(cfgReadData),
    .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgDword(cfgDword), .cfgByteEn(cfgByteEn),
    .cfgWriteData(cfgWriteData));

  pci_pm_capability u_pci_pm_capability (.clk(clk), .rst_n(rst_n), .pciReset_n(pciReset_n),
    .auxPresentPin(auxPresentPin), .eepromCapLoad(eepromCapLoad),
    .eepromCapWord(eepromCapWord), .eepromScaleLoad(eepromScaleLoad),
    .eepromScaleIndex(eepromScaleIndex), .eepromScaleValue(eepromScaleValue),
    .wakeEvent(wakeEvent), .cfgRead(cfgRead), .cfgWrite(cfgWrite), .cfgDword(cfgDword),
    .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData), .cfgReadData(cfgReadData),
    .cfgAck(cfgAck), .cfgHit(cfgHit), .devicePowerLevel(devicePowerLevel),
    .hotResetPulse(hotResetPulse), .capReady(capReady), .wakeOut(wakeOut),
    .wakeOutEnable(wakeOutEnable));

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                      input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    u_cfg_host_model.access(wr, dw, be, wd, rd, ok);
    hotSeen = hotResetPulse;
    if (!ok) begin
      n_errors++;
      $display("unexpected cfgAck: expected 1, seen 0");
      end_of_test();
    end
  endtask

  task automatic rd(input logic [5:0] dw, input logic [31:0] exp);
    logic [31:0] d;
    xfer(1'b0, dw, 4'hf, 32'h0, d);
    check("cfgReadData", exp, d);
  endtask

  task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, dw, be, wd, d);
  endtask

  // strap must settle before reset is released
  task automatic pwrup(input logic aux);
    int n;
    @(negedge clk);
    rst_n = 1'b0;
    auxPresentPin = aux;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    for (n = 0; n < 10 && capReady !== 1'b1; n++) @(negedge clk);
    check("capReady", 32'h1, {31'h0, capReady});
  endtask

  task automatic wake();
    @(negedge clk);
    wakeEvent = 1'b1;
    @(negedge clk);
    wakeEvent = 1'b0;
  endtask

  task automatic pciRst();
    @(negedge clk);
    pciReset_n = 1'b0;
    @(negedge clk);
    pciReset_n = 1'b1;
  endtask

  task automatic capLoad(input logic [15:0] w);
    @(negedge clk);
    eepromCapWord = w;
    eepromCapLoad = 1'b1;
    @(negedge clk);
    eepromCapLoad = 1'b0;
  endtask

  task automatic scaleLoad(input logic [2:0] idx, input logic [1:0] v);
    @(negedge clk);
    eepromScaleIndex = idx;
    eepromScaleValue = v;
    eepromScaleLoad = 1'b1;
    @(negedge clk);
    eepromScaleLoad = 1'b0;
  endtask

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    pwrup(1'b1);
    rd(6'h11, 32'hffc20001);
    rd(6'h12, 32'h0);
    wr(6'h11, 4'hf, 32'h0);
    rd(6'h11, 32'hffc20001);
    rd(6'h05, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(6'h12, 4'h1, 32'hfc | i);
      rd(6'h12, i);
      check("devicePowerLevel", i, devicePowerLevel);
    end
    wr(6'h12, 4'h1, 32'h0);
    check("hotResetPulse", 32'h1, hotSeen);
    // entry 0 keeps scale 0 so later reads at select 0 show no scale
    for (i = 0; i < 8; i++) scaleLoad(i[2:0], i[1:0]);
    for (i = 0; i < 10; i++) begin
      wr(6'h12, 4'h2, i << 9);
      rd(6'h12, ((i < 8) ? ((i % 4) << 13) : 0) | (i << 9));
    end
    wr(6'h12, 4'h2, 32'h100);
    wake();
    check("wakeOutEnable", 32'h1, wakeOutEnable);
    wr(6'h12, 4'h2, 32'h100);
    rd(6'h12, 32'h8100);
    wr(6'h12, 4'h1, 32'h3);
    wr(6'h12, 4'h1, 32'h0);
    check("hotResetPulse", 32'h1, hotSeen);
    rd(6'h12, 32'h8100);
    wr(6'h12, 4'h1, 32'h2);
    pciRst();
    rd(6'h12, 32'h8100);
    check("wakeOutEnable", 32'h1, wakeOutEnable);
    wr(6'h12, 4'h2, 32'h8100);
    check("wakeOutEnable", 32'h0, wakeOutEnable);
    rd(6'h12, 32'h0100);
    wr(6'h12, 4'h2, 32'h0);
    wake();
    check("wakeOutEnable", 32'h0, wakeOutEnable);
    rd(6'h12, 32'h8000);
    wr(6'h12, 4'h2, 32'h8000);
    rd(6'h12, 32'h0);
    capLoad(16'h0);
    rd(6'h11, 32'h7e020001);
    wr(6'h12, 4'h2, 32'h100);
    wake();
    pciRst();
    rd(6'h12, 32'h0);
    check("wakeOutEnable", 32'h0, wakeOutEnable);
    capLoad(16'h8140);
    rd(6'h11, 32'hff420001);
    pwrup(1'b0);
    rd(6'h11, 32'h7e020001);
    capLoad(16'hffff);
    rd(6'h11, 32'h7e020001);
    end_of_test();
  end
endmodule

bind pci_pm_capability pci_pm_capability_chk u_pci_pm_capability_chk (.clk(clk), .rst_n(rst_n),
  .pciReset_n(pciReset_n), .wakeEvent(wakeEvent), .cfgRead(cfgRead), .cfgWrite(cfgWrite),
  .cfgDword(cfgDword), .cfgByteEn(cfgByteEn), .cfgWriteData(cfgWriteData),
  .cfgReadData(cfgReadData), .cfgAck(cfgAck), .cfgHit(cfgHit),
  .devicePowerLevel(devicePowerLevel), .hotResetPulse(hotResetPulse), .capReady(capReady),
  .wakeOut(wakeOut), .wakeOutEnable(wakeOutEnable));

`default_nettype wire
